// ===== scg_cfg.svh
// constants for the serial port clock generator
`ifndef SCG_CFG_SVH
`define SCG_CFG_SVH
`define SCG_BAUD_W        16
`define SCG_INT_LSB       6
`define SCG_FRAC_W        6
`define SCG_INT_W         10
`define SCG_NUM_SCALE     64
`define SCG_SPB_NORMAL    16
`define SCG_SPB_DOUBLE    8
`define SCG_SPB_SYNC      2
`define SCG_ACC_W         24
`define SCG_XCK_DIV_MIN   4
`define SCG_CLK_PERIOD_PS 5000
`endif

// ===== scg_pkg.sv
// types for the serial port clock generator
package scg_pkg;
  typedef enum logic [2:0] {
    SCG_ASYNC_NORMAL,
    SCG_ASYNC_DOUBLE,
    SCG_SYNC_MASTER,
    SCG_SYNC_SLAVE,
    SCG_SPI_MASTER
  } scg_mode_t;
endpackage : scg_pkg

// ===== scg_edge_if.sv
// interface carrying the synchronised transfer clock edges
`timescale 1ns/1ps
`default_nettype none
interface scg_edge_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface : scg_edge_if
`default_nettype wire

// ===== scg_xck_sync.sv
// two-stage synchroniser and edge detector for the transfer clock input
`timescale 1ns/1ps
`default_nettype none
`include "scg_cfg.svh"
module scg_xck_sync (
  input  wire logic  mclk,
  input  wire logic  rst,
  input  wire logic  pin_in,
  input  wire logic  invert,
  scg_edge_if.src    edge_o
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } scg_sync_st_t;
  scg_sync_st_t st_q, st_d;
  logic         pin_inv;

  // inversion sits ahead of the flops so both edges see the same polarity
  assign pin_inv = pin_in ^ invert;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    st_d      = st_q;
    st_d.meta = pin_inv;
    st_d.sync = st_q.meta;
    st_d.last = st_q.sync;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // edges come only from the second stage onward
  assign edge_o.level = st_q.sync;
  assign edge_o.rise  = st_q.sync & ~st_q.last;
  assign edge_o.fall  = ~st_q.sync & st_q.last;
endmodule : scg_xck_sync
`default_nettype wire

// ===== scg_clock_gen.sv
// serial port clock generator: fractional baud, sync master/slave and spi clocking
// ************************************************************
// Summary of operation
// - keeps running in debug halt unless stop-in-debug is set, then freezes.
// - supports normal, double-speed async, sync master, sync slave, spi master clocking.
// - async divisor is 16 bits: ten integer bits, six fraction bits.
// - sync modes ignore fraction; rate is clock over twice integer part.
// - async rate equals 64 times clock over samples-per-bit times divisor.
// - samples per bit 16 normal, 8 double-speed, 2 synchronous.
// - internal generator clocks async, sync master and spi master modes.
// - sync slave takes bit clock from synchronised transfer clock pin edges.
// - double speed doubles bit rate and halves receiver samples per bit.
// - sync role follows transfer clock pin direction; port overrides the pin.
// - receive samples on the edge opposite the transmit change edge.
// - without inversion data changes on rising, samples on falling, except spi phase 0; inversion swaps.
// - spi master uses only internal generator with the synchronous equation.
// - spi leading edge samples with phase 0, sets up with phase 1.
// ************************************************************
`timescale 1ns/1ps
`default_nettype none
`include "scg_cfg.svh"
module scg_clock_gen #(
  parameter int BAUD_W = `SCG_BAUD_W
) (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic                  enable,
  input  wire logic [BAUD_W-1:0]     baud_divisor,
  input  wire logic                  double_speed_setting,
  input  wire logic                  communication_mode_select,
  input  wire logic                  spi_master_select,
  input  wire logic                  transfer_clock_dir_out,
  input  wire logic                  pin_invert_enable,
  input  wire logic                  spi_clock_phase,
  input  wire logic                  debug_halt,
  input  wire logic                  debug_stop_enable,
  input  wire logic                  transfer_clock_pin_in,
  output logic                       transfer_clock_pin_out,
  output logic                       transfer_clock_pin_oe_n,
  output logic                       txclk,
  output logic                       rxclk,
  output logic [4:0]                 samples_per_bit,
  output var scg_pkg::scg_mode_t     mode
);
  localparam int INT_W = `SCG_INT_W;
  localparam int ACC_W = `SCG_ACC_W;

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [ACC_W-1:0] acc;
    logic [INT_W-1:0] half_cnt;
    logic             xck_level;
    logic             txclk;
    logic             rxclk;
  } scg_st_t;
  scg_st_t st_q, st_d;

  scg_edge_if xedge ();
  logic       run;
  logic       tick_async;
  logic [ACC_W-1:0] step;
  logic [ACC_W-1:0] acc_sum;
  logic [INT_W-1:0] int_part;
  logic       change_edge_sel;

  // freezes only when the halt is asked for; default is to keep running
  assign run = enable & ~(debug_halt & debug_stop_enable);

  // mode decode: pin direction picks master or slave in sync operation
  always_comb begin
    if (spi_master_select) begin
      mode = scg_pkg::SCG_SPI_MASTER;
    end else if (communication_mode_select) begin
      mode = transfer_clock_dir_out ? scg_pkg::SCG_SYNC_MASTER : scg_pkg::SCG_SYNC_SLAVE;
    end else begin
      mode = double_speed_setting ? scg_pkg::SCG_ASYNC_DOUBLE : scg_pkg::SCG_ASYNC_NORMAL;
    end
  end

  // samples per bit by mode; double speed halves the receiver oversampling
  always_comb begin
    case (mode)
      scg_pkg::SCG_ASYNC_NORMAL: samples_per_bit = 5'(`SCG_SPB_NORMAL);
      scg_pkg::SCG_ASYNC_DOUBLE: samples_per_bit = 5'(`SCG_SPB_DOUBLE);
      default:                   samples_per_bit = 5'(`SCG_SPB_SYNC);
    endcase
  end

  scg_xck_sync u_xck_sync (
    .mclk   (mclk),
    .rst    (rst),
    .pin_in (transfer_clock_pin_in),
    .invert (pin_invert_enable),
    .edge_o (xedge.src)
  );

  // ************************************************************
  // fractional generator
  // ************************************************************
  // sample tick rate = clk*64/baud; a bit is S ticks, so bit rate = 64*clk/(S*baud)
  // accumulator of 64 per clock; fraction resolved by carrying the remainder
  assign step     = ACC_W'(`SCG_NUM_SCALE);
  assign acc_sum  = st_q.acc + step;
  assign tick_async = (baud_divisor != '0) && (acc_sum >= ACC_W'(baud_divisor));
  assign int_part = baud_divisor[BAUD_W-1:`SCG_INT_LSB];

  // works on the internal level, before pin inversion, so inversion alone swaps the pin edges;
  // spi phase 0 samples on the leading edge, which puts the change on the trailing edge
  assign change_edge_sel = spi_master_select & ~spi_clock_phase;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    st_d       = st_q;
    st_d.txclk = 1'b0;
    st_d.rxclk = 1'b0;
    if (run) begin
      case (mode)
        scg_pkg::SCG_ASYNC_NORMAL, scg_pkg::SCG_ASYNC_DOUBLE: begin
          // internal generator; tick is a sample strobe, rate capped at one per clock
          if (tick_async) begin
            st_d.acc   = acc_sum - ACC_W'(baud_divisor);
            st_d.txclk = 1'b1;
            st_d.rxclk = 1'b1;
          end else begin
            st_d.acc = acc_sum;
          end
        end
        scg_pkg::SCG_SYNC_MASTER, scg_pkg::SCG_SPI_MASTER: begin
          // toggle every integer count: period is 2*int clocks, fraction unused
          if (int_part == '0) begin
            st_d.half_cnt = '0;
          end else if (st_q.half_cnt >= int_part - INT_W'(1)) begin
            st_d.half_cnt  = '0;
            st_d.xck_level = ~st_q.xck_level;
            // level is in pin sense before inversion; its rising edge is the change edge unless change_edge_sel is set
            if (~st_q.xck_level ^ change_edge_sel) begin
              st_d.txclk = 1'b1;
            end else begin
              st_d.rxclk = 1'b1;
            end
          end else begin
            st_d.half_cnt = st_q.half_cnt + INT_W'(1);
          end
        end
        scg_pkg::SCG_SYNC_SLAVE: begin
          // synchroniser already applied inversion, so rise is always change edge
          st_d.txclk = xedge.rise;
          st_d.rxclk = xedge.fall;
          st_d.half_cnt  = '0;
          st_d.xck_level = 1'b0;
        end
        default: begin
          st_d = st_q;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // port drives the pin only as master; slave leaves it as input
  assign transfer_clock_pin_out  = st_q.xck_level ^ pin_invert_enable;
  assign transfer_clock_pin_oe_n = ~(mode == scg_pkg::SCG_SYNC_MASTER || mode == scg_pkg::SCG_SPI_MASTER);
  assign txclk = st_q.txclk;
  assign rxclk = st_q.rxclk;
endmodule : scg_clock_gen
`default_nettype wire

// ===== scg_checker.sv
// assertions on the clock generator ports
`timescale 1ns/1ps
`default_nettype none
module scg_checker #(parameter int BAUD_W = 16) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic enable,
  input wire logic [BAUD_W-1:0] baud_divisor,
  input wire logic double_speed_setting,
  input wire logic communication_mode_select,
  input wire logic spi_master_select,
  input wire logic transfer_clock_dir_out,
  input wire logic pin_invert_enable,
  input wire logic spi_clock_phase,
  input wire logic debug_halt,
  input wire logic debug_stop_enable,
  input wire logic transfer_clock_pin_in,
  input wire logic transfer_clock_pin_out,
  input wire logic transfer_clock_pin_oe_n,
  input wire logic txclk,
  input wire logic rxclk,
  input wire logic [4:0] samples_per_bit
);
  // ********
  // helpers
  // ********
  logic frz, mst, asy, slv, flip, ev, pv_q;
  logic [1:0] seen_q;
  logic [9:0] cnt_q;
  assign frz = debug_halt & debug_stop_enable;
  assign mst = enable & ~frz & (spi_master_select | communication_mode_select & transfer_clock_dir_out);
  assign asy = enable & ~frz & ~spi_master_select & ~communication_mode_select;
  assign slv = enable & ~frz & ~spi_master_select & communication_mode_select & ~transfer_clock_dir_out;
  assign flip = pin_invert_enable ^ (spi_master_select & ~spi_clock_phase);
  assign ev = mst ? (transfer_clock_pin_out != pv_q) : txclk;
  // cycles since last toggle or tick; the first two events are skipped as start-up may be short
  always_ff @(posedge mclk) begin
    pv_q <= transfer_clock_pin_out;
    if (rst | ~(mst | asy)) begin
      seen_q <= 2'h0;
      cnt_q <= 10'h000;
    end else begin
      seen_q <= (ev & ~seen_q[1]) ? seen_q + 2'h1 : seen_q;
      cnt_q <= ev ? 10'h000 : cnt_q + 10'h001;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_rise; $rose(transfer_clock_pin_in ^ pin_invert_enable); endsequence
  sequence s_fall; $fell(transfer_clock_pin_in ^ pin_invert_enable); endsequence
  AST_SPB_ASYNC: assert property (!communication_mode_select && !spi_master_select |->
    samples_per_bit == (double_speed_setting ? 5'h08 : 5'h10)) else $error("async spb wrong");
  AST_SPB_SYNC: assert property (communication_mode_select || spi_master_select |-> samples_per_bit == 5'h02)
    else $error("sync spb wrong");
  AST_OE_SYNC: assert property (enable && communication_mode_select && !spi_master_select |->
    transfer_clock_pin_oe_n == !transfer_clock_dir_out) else $error("pin direction wrong");
  AST_OE_SPI: assert property (enable && spi_master_select |-> !transfer_clock_pin_oe_n)
    else $error("spi pin not driven");
  AST_FREEZE: assert property (frz && $past(frz) |-> !txclk && !rxclk) else $error("strobe in freeze");
  AST_ASYNC_PAIR: assert property (asy |-> txclk == rxclk) else $error("async strobes split");
  AST_TX_EDGE: assert property (mst && txclk |-> $changed(transfer_clock_pin_out) &&
    transfer_clock_pin_out == !flip) else $error("change strobe on wrong edge");
  AST_RX_EDGE: assert property (mst && rxclk |-> $changed(transfer_clock_pin_out) &&
    transfer_clock_pin_out == flip) else $error("sample strobe on wrong edge");
  AST_RATE: assert property ((mst || asy && baud_divisor[5:0] == 6'h00) && seen_q[1] && ev |->
    cnt_q == baud_divisor[15:6] - 10'h001) else $error("interval wrong");
  AST_SLAVE_TX: assert property (slv ##0 s_rise |-> ##[1:5] txclk) else $error("no change strobe");
  AST_SLAVE_RX: assert property (slv ##0 s_fall |-> ##[1:5] rxclk) else $error("no sample strobe");
endmodule : scg_checker
`default_nettype wire

// ===== scg_remote.sv
// remote transceiver driving the transfer clock in slave mode
`timescale 1ns/1ps
`default_nettype none
module scg_remote (
  input wire logic run,
  output logic xck
);
  // 25 ns half period: ten mclk cycles a bit, well under a quarter of mclk; parked low when idle
  initial xck = 1'b0;
  always begin
    #25;
    xck = run ? ~xck : 1'b0;
  end
endmodule : scg_remote
`default_nettype wire

// ===== tb.sv
// testbench for the clock generator
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ********
  // bench
  // ********
  logic mclk = 1'b0, rst = 1'b1, enable = 1'b0, run = 1'b0, debug_halt = 1'b0, debug_stop_enable = 1'b0;
  logic [15:0] baud_divisor = 16'h0100;
  logic double_speed_setting = 1'b0, communication_mode_select = 1'b0, spi_master_select = 1'b0;
  logic transfer_clock_dir_out = 1'b0, pin_invert_enable = 1'b0, spi_clock_phase = 1'b0;
  logic transfer_clock_pin_in, transfer_clock_pin_out, transfer_clock_pin_oe_n, txclk, rxclk, pv, pi;
  logic [4:0] samples_per_bit;
  scg_pkg::scg_mode_t mode;
  int n_mismatch = 0, check_count = 0, sp;
  logic [3:0] cfgt [5] = '{4'h0, 4'h1, 4'h6, 4'h4, 4'he};
  logic [4:0] spbt [5] = '{5'h10, 5'h08, 5'h02, 5'h02, 5'h02};
  always #2.5 mclk = ~mclk;
  scg_clock_gen DUT (.*);
  scg_remote PEER (.run(run), .xck(transfer_clock_pin_in));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // settings move only while stopped, so no transfer sees them change; enable comes last
  task automatic cfg(input logic [3:0] c, input logic inv, input logic ph, input logic [15:0] b);
    @(posedge mclk) #1 enable = 1'b0;
    {spi_master_select, communication_mode_select, transfer_clock_dir_out, double_speed_setting} = c;
    pin_invert_enable = inv;
    spi_clock_phase = ph;
    baud_divisor = b;
    @(posedge mclk) #1 enable = 1'b1;
  endtask : cfg
  // cycles over n change strobes, keeping pin levels at the last; gives up after 300
  task automatic meas(input int n, output int span);
    span = 0;
    repeat (n) begin
      do begin
        @(posedge mclk) #1;
        span++;
      end while (txclk !== 1'b1 && span < 300);
      pv = transfer_clock_pin_out;
      pi = transfer_clock_pin_in;
    end
  endtask : meas
  task finish_test;
    $display("mismatches %0d, checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  initial begin
    repeat (4) @(posedge mclk);
    #1 rst = 1'b0;
    chk(16'(txclk), 16'h0000);
    chk(16'(transfer_clock_pin_out), 16'(pin_invert_enable));
    // every mode: decode and samples per bit; pin direction for the three sync-clocked modes
    for (int i = 0; i < 5; i++) begin
      cfg(cfgt[i], 1'b0, 1'b0, 16'h0100);
      chk(16'(mode), 16'(i));
      chk(16'(samples_per_bit), 16'(spbt[i]));
      if (i > 1) chk(16'(transfer_clock_pin_oe_n), 16'(i == 3));
    end
    // async: 4.0 ticks every 4 cycles, 4.5 spans 72 over 16; double speed ticks alike
    for (int d = 0; d < 2; d++) begin
      cfg(4'(d), 1'b0, 1'b0, 16'h0100);
      meas(1, sp);
      meas(1, sp);
      chk(16'(sp), 16'h0004);
      cfg(4'(d), 1'b0, 1'b0, 16'h0120);
      meas(1, sp);
      meas(16, sp);
      chk(16'(sp), 16'h0048);
    end
    // sync and spi master with every inversion and phase; fraction must be ignored
    for (int k = 0; k < 8; k++) begin
      cfg({k[2], 3'b110}, k[1], k[0], 16'h0120);
      meas(1, sp);
      meas(4, sp);
      chk(16'(sp), 16'h0020);
      chk(16'(pv), 16'(!(k[1] ^ (k[2] & !k[0]))));
    end
    // slave: remote clock of ten cycles, change strobe follows the inversion
    run = 1'b1;
    for (int k = 0; k < 2; k++) begin
      cfg(4'h4, k[0], 1'b0, 16'h0120);
      meas(1, sp);
      meas(1, sp);
      chk(16'(sp), 16'h000a);
      chk(16'(pi), 16'(!k[0]));
    end
    run = 1'b0;
    repeat (10) @(posedge mclk);
    // debug halt keeps ticking unless stop is set too
    cfg(4'h0, 1'b0, 1'b0, 16'h0100);
    debug_halt = 1'b1;
    meas(1, sp);
    meas(1, sp);
    chk(16'(sp), 16'h0004);
    debug_stop_enable = 1'b1;
    meas(1, sp);
    chk(16'(sp), 16'h012c);
    debug_stop_enable = 1'b0;
    meas(1, sp);
    meas(1, sp);
    chk(16'(sp), 16'h0004);
    finish_test();
  end
  // watchdog, far beyond the less than a thousand cycles the tests need
  initial begin
    #100us;
    n_mismatch++;
    finish_test();
  end
endmodule : tb
bind scg_clock_gen scg_checker #(.BAUD_W(BAUD_W)) CHK (.*);
`default_nettype wire
